/* hdl/drive_seq_defs.svh */
// Constants for the drive brake, jog and up-down sequencer
// Function
// - Stop mode 1 ends a run with DC injection braking.
// - Braking starts when decelerating output reaches brake start frequency.
// - Output is 0 for brake wait time before DC level is applied.
// - Stop brake level is a percent of motor rated current, default 50.
// - DC level is applied for brake time, then the stop ends.
// - Zero stop brake level or time skips stop braking entirely.
// - Run applies start DC level for start brake time, then accelerates.
// - Zero start level or start time means no DC injection at start.
// - Input code 11 while stopped applies DC at start level.
// - Input code 4 runs at the jog frequency.
// - Jog frequency is kept between start and maximum frequency.
// - Jog overrides every other frequency source.
// - Codes 26 and 27 are forward and reverse jog.
// - Up-down active with method 8; code 15 raises, 16 lowers.
// - Save option 1 stores frequency before stop; option 0 stores nothing.
// - Code 25 clears saved frequency, ignored while up or down held.
// - Mode 0 ramps while held, up to maximum, down to lower limit.
// - Mode 1 steps per edge; saves at falling edge when enabled.
// - Mode 1 stop keeps earlier saved value; no save otherwise.
// - Mode 2 steps per rising edge; after 3 s held ramps like mode 0.
// - Edges during an unfinished step are ignored; save at release.
// - Motor rated current defaults to 26.3 A, reference for DC levels.
// - Commands below start frequency become 0.00.
`ifndef DRIVE_SEQ_DEFS_SVH
`define DRIVE_SEQ_DEFS_SVH

// Timing
`define CLK_PERIOD_NS       40
`define TENTH_PERIOD_NS     100000000
`define RAMP_PERIOD_NS      10000000
`define TENTH_CYCLES        (`TENTH_PERIOD_NS / `CLK_PERIOD_NS)
`define RAMP_CYCLES         (`RAMP_PERIOD_NS / `CLK_PERIOD_NS)
`define UD_HOLD_TIME_S      3
`define UD_HOLD_TICKS       5'(`UD_HOLD_TIME_S * 10)

// Register offsets
`define REG_CTRL            6'h00
`define REG_BRK_START_FREQ  6'h01
`define REG_BRK_WAIT        6'h02
`define REG_STOP_LEVEL      6'h03
`define REG_STOP_TIME       6'h04
`define REG_START_LEVEL     6'h05
`define REG_START_TIME      6'h06
`define REG_JOG_FREQ        6'h07
`define REG_MAX_FREQ        6'h08
`define REG_START_FREQ      6'h09
`define REG_STEP_FREQ       6'h0A
`define REG_SAVED_FREQ      6'h0B
`define REG_RATED_CURRENT   6'h0C
`define REG_RAMP_STEP       6'h0D
`define REG_REF_FREQ        6'h0E
`define REG_FSEL_BASE       3'h2
`define REG_STATUS          6'h18
`define REG_OUT_FREQ        6'h19
`define REG_UD_REF          6'h1A

// Control register fields
`define CTRL_STOP_MODE      1:0
`define CTRL_METHOD         5:2
`define CTRL_UD_MODE        7:6
`define CTRL_SAVE_EN        8

// Reset values (frequency 0.01 Hz, time 0.1 s, current 0.1 A)
`define RST_CTRL            16'h0000
`define RST_BRK_START_FREQ  16'h01F4
`define RST_BRK_WAIT        10'h001
`define RST_STOP_LEVEL      8'h32
`define RST_STOP_TIME       10'h00A
`define RST_START_LEVEL     8'h32
`define RST_START_TIME      10'h000
`define RST_JOG_FREQ        16'h03E8
`define RST_MAX_FREQ        16'h1770
`define RST_START_FREQ      16'h0032
`define RST_STEP_FREQ       16'h0000
`define RST_SAVED_FREQ      16'h0000
`define RST_RATED_CURRENT   11'h107
`define RST_RAMP_STEP       16'h0005
`define RST_REF_FREQ        16'h0000
`define RST_FSEL            5'h00

// Codes
`define STOP_DC_BRAKE       2'h1
`define STOP_FREE_RUN       2'h2
`define METHOD_UPDOWN       4'h8
`define UD_MODE_RAMP        2'h0
`define UD_MODE_EDGE        2'h1
`define UD_MODE_COMBO       2'h2
`define FN_JOG              5'h04
`define FN_DC_AT_STOP       5'h0B
`define FN_UP               5'h0F
`define FN_DOWN             5'h10
`define FN_SAVE_CLEAR       5'h19
`define FN_FWD_JOG          5'h1A
`define FN_REV_JOG          5'h1B
`define PERCENT_DIV         19'h00064

`endif

/* hdl/drive_seq_pkg.sv */
// Types shared by the drive sequencer
package drive_seq_pkg;
    typedef enum logic [2:0] {
        ST_STOP,
        ST_START_DC,
        ST_RUN,
        ST_DECEL,
        ST_WAIT,
        ST_BRAKE
    } seq_state_t;
endpackage : drive_seq_pkg

/* hdl/tick_divider.sv */
// Divider for the 0.1 s timing tick and the ramp tick
`timescale 1ns/1ps
module tick_divider #(
    parameter int TENTH_CYCLES = 2500000,
    parameter int RAMP_CYCLES  = 250000
) (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // Ticks
    output logic      tenth_tick_o,
    output logic      ramp_tick_o
);
    logic [22:0] tenth_cnt;
    logic [22:0] ramp_cnt;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            tenth_cnt    <= 23'h000000;
            tenth_tick_o <= 1'b0;
        end else if (tenth_cnt == 23'(TENTH_CYCLES - 1)) begin
            tenth_cnt    <= 23'h000000;
            tenth_tick_o <= 1'b1;
        end else begin
            tenth_cnt    <= tenth_cnt + 23'h000001;
            tenth_tick_o <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ramp_cnt    <= 23'h000000;
            ramp_tick_o <= 1'b0;
        end else if (ramp_cnt == 23'(RAMP_CYCLES - 1)) begin
            ramp_cnt    <= 23'h000000;
            ramp_tick_o <= 1'b1;
        end else begin
            ramp_cnt    <= ramp_cnt + 23'h000001;
            ramp_tick_o <= 1'b0;
        end
    end
endmodule : tick_divider

/* hdl/drive_sequencer.sv */
// Run sequencer: DC braking, jog and up-down frequency control
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "drive_seq_defs.svh"
module drive_sequencer
    import drive_seq_pkg::*;
#(
    parameter int TENTH_CYCLES = `TENTH_CYCLES,
    parameter int RAMP_CYCLES  = `RAMP_CYCLES
) (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // Register port
    input  wire logic [5:0]  addr_i,
    input  wire logic [15:0] wr_data_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rd_data_o,
    // Terminals
    input  wire logic        run_i,
    input  wire logic [7:0]  mfi_i,
    // Modulator command
    output logic      [15:0] out_freq_o,
    output logic      [7:0]  dc_level_o,
    output logic      [11:0] dc_current_o,
    output logic             reverse_o,
    output logic             brake_active_o,
    output logic             running_o
);
    logic [15:0] ctrl;
    logic [15:0] brk_start_freq;
    logic [9:0]  brk_wait;
    logic [7:0]  stop_level;
    logic [9:0]  stop_time;
    logic [7:0]  start_level;
    logic [9:0]  start_time;
    logic [15:0] jog_freq;
    logic [15:0] max_freq;
    logic [15:0] start_freq;
    logic [15:0] step_freq;
    logic [15:0] saved_freq;
    logic [10:0] rated_current;
    logic [15:0] ramp_step;
    logic [15:0] ref_freq;
    logic [4:0]  fsel [8];

    logic        tenth_tick;
    logic        ramp_tick;
    logic        run_meta;
    logic        run_sync;
    logic [7:0]  mfi_meta;
    logic [7:0]  mfi_sync;
    logic [7:0]  is_jog;
    logic [7:0]  is_fjog;
    logic [7:0]  is_rjog;
    logic [7:0]  is_dcstop;
    logic [7:0]  is_up;
    logic [7:0]  is_dn;
    logic [7:0]  is_clr;
    logic        up_lvl;
    logic        dn_lvl;
    logic        up_prev;
    logic        dn_prev;
    logic        run_cmd;
    logic        jog_on;
    logic        brake_on;
    logic        stop_evt;
    logic        ud_on;
    seq_state_t  state;
    logic [9:0]  timer;
    logic [9:0]  cur_time;
    logic        time_up;
    logic [15:0] jog_lim;
    logic [15:0] src_freq;
    logic [15:0] target;
    logic [15:0] ud_ref;
    logic [4:0]  hold_cnt;
    logic        ud_cont;
    logic        ud_busy;
    logic [16:0] ud_sum;
    logic [15:0] next_rd_data;
    logic [18:0] dc_product;

    tick_divider #(
        .TENTH_CYCLES (TENTH_CYCLES),
        .RAMP_CYCLES  (RAMP_CYCLES)
    ) u_tick (
        .ref_clk_i    (ref_clk_i),
        .rst_i        (rst_i),
        .tenth_tick_o (tenth_tick),
        .ramp_tick_o  (ramp_tick)
    );

    function automatic logic [15:0] step_toward(input logic [15:0] cur,
                                                input logic [15:0] tgt,
                                                input logic [15:0] stp);
        logic [16:0] sum;
        sum = {1'b0, cur} + {1'b0, stp};
        if (cur < tgt) begin
            step_toward = (sum > {1'b0, tgt}) ? tgt : sum[15:0];
        end else if (cur > tgt) begin
            step_toward = (stp >= cur - tgt) ? tgt : cur - stp;
        end else begin
            step_toward = cur;
        end
    endfunction : step_toward

    // Terminal synchronisers
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            run_meta <= 1'b0;
            run_sync <= 1'b0;
            mfi_meta <= 8'h00;
            mfi_sync <= 8'h00;
        end else begin
            run_meta <= run_i;
            run_sync <= run_meta;
            mfi_meta <= mfi_i;
            mfi_sync <= mfi_meta;
        end
    end

    // Input function decode, one slice per terminal
    for (genvar g = 0; g < 8; g++) begin : g_fn
        assign is_jog[g]    = mfi_sync[g] && (fsel[g] == `FN_JOG);
        assign is_fjog[g]   = mfi_sync[g] && (fsel[g] == `FN_FWD_JOG);
        assign is_rjog[g]   = mfi_sync[g] && (fsel[g] == `FN_REV_JOG);
        assign is_dcstop[g] = mfi_sync[g] && (fsel[g] == `FN_DC_AT_STOP);
        assign is_up[g]     = mfi_sync[g] && (fsel[g] == `FN_UP);
        assign is_dn[g]     = mfi_sync[g] && (fsel[g] == `FN_DOWN);
        assign is_clr[g]    = mfi_sync[g] && (fsel[g] == `FN_SAVE_CLEAR);
    end

    assign up_lvl   = |is_up;
    assign dn_lvl   = |is_dn;
    assign jog_on   = |{is_jog, is_fjog, is_rjog};
    assign run_cmd  = run_sync || jog_on;
    assign ud_on    = ctrl[`CTRL_METHOD] == `METHOD_UPDOWN;
    assign brake_on = (ctrl[`CTRL_STOP_MODE] == `STOP_DC_BRAKE)
                      && (stop_level != 8'h00) && (stop_time != 10'h000);
    assign stop_evt = (state == ST_RUN) && !run_cmd;

    // Frequency source selection and limits
    always_comb begin
        if (jog_freq < start_freq) begin
            jog_lim = start_freq;
        end else if (jog_freq > max_freq) begin
            jog_lim = max_freq;
        end else begin
            jog_lim = jog_freq;
        end
        if (jog_on) begin
            src_freq = jog_lim;
        end else if (ud_on) begin
            src_freq = ud_ref;
        end else begin
            src_freq = ref_freq;
        end
        target = (src_freq > max_freq) ? max_freq : src_freq;
        if (target < start_freq) begin
            target = 16'h0000;
        end
    end

    // Duration for the timed state
    always_comb begin
        unique case (state)
            ST_START_DC: cur_time = start_time;
            ST_WAIT:     cur_time = brk_wait;
            ST_BRAKE:    cur_time = stop_time;
            default:     cur_time = 10'h000;
        endcase
        time_up = (cur_time == 10'h000) ||
                  (tenth_tick && ({1'b0, timer} + 11'h001 >= {1'b0, cur_time}));
    end

    // Run, stop and brake sequencing
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state      <= ST_STOP;
            timer      <= 10'h000;
            out_freq_o <= 16'h0000;
            dc_level_o <= 8'h00;
            reverse_o  <= 1'b0;
        end else begin
            unique case (state)
                ST_STOP: begin
                    out_freq_o <= 16'h0000;
                    timer      <= 10'h000;
                    reverse_o  <= |is_rjog;
                    if (run_cmd && (start_level != 8'h00) && (start_time != 10'h000)) begin
                        state      <= ST_START_DC;
                        dc_level_o <= start_level;
                    end else if (run_cmd) begin
                        state      <= ST_RUN;
                        dc_level_o <= 8'h00;
                    end else begin
                        dc_level_o <= (|is_dcstop) ? start_level : 8'h00;
                    end
                end
                ST_START_DC: begin
                    if (!run_cmd) begin
                        state      <= ST_STOP;
                        dc_level_o <= 8'h00;
                    end else if (time_up) begin
                        state      <= ST_RUN;
                        dc_level_o <= 8'h00;
                    end else if (tenth_tick) begin
                        timer <= timer + 10'h001;
                    end
                end
                ST_RUN: begin
                    if (!run_cmd && ctrl[`CTRL_STOP_MODE] == `STOP_FREE_RUN) begin
                        state      <= ST_STOP;
                        out_freq_o <= 16'h0000;
                    end else if (!run_cmd) begin
                        state <= ST_DECEL;
                    end else if (ramp_tick) begin
                        out_freq_o <= step_toward(out_freq_o, target, ramp_step);
                    end
                end
                ST_DECEL: begin
                    if (run_cmd) begin
                        state <= ST_RUN;
                    end else if (brake_on && out_freq_o <= brk_start_freq) begin
                        state      <= ST_WAIT;
                        out_freq_o <= 16'h0000;
                        timer      <= 10'h000;
                    end else if (out_freq_o == 16'h0000) begin
                        state <= ST_STOP;
                    end else if (ramp_tick) begin
                        out_freq_o <= step_toward(out_freq_o, 16'h0000, ramp_step);
                    end
                end
                ST_WAIT: begin
                    out_freq_o <= 16'h0000;
                    dc_level_o <= 8'h00;
                    if (time_up) begin
                        state      <= ST_BRAKE;
                        timer      <= 10'h000;
                        dc_level_o <= stop_level;
                    end else if (tenth_tick) begin
                        timer <= timer + 10'h001;
                    end
                end
                ST_BRAKE: begin
                    if (time_up) begin
                        state      <= ST_STOP;
                        dc_level_o <= 8'h00;
                    end else if (tenth_tick) begin
                        timer <= timer + 10'h001;
                    end
                end
                default: begin
                    state <= ST_STOP;
                end
            endcase
        end
    end

    // DC current command and status outputs
    assign dc_product = 19'(dc_level_o) * 19'(rated_current);
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            dc_current_o   <= 12'h000;
            brake_active_o <= 1'b0;
            running_o      <= 1'b0;
        end else begin
            dc_current_o   <= 12'(dc_product / `PERCENT_DIV);
            brake_active_o <= (dc_level_o != 8'h00);
            running_o      <= (state == ST_RUN) || (state == ST_DECEL);
        end
    end

    // Up-down reference and saved frequency
    assign ud_cont = (ctrl[`CTRL_UD_MODE] == `UD_MODE_RAMP) ||
                     (ctrl[`CTRL_UD_MODE] == `UD_MODE_COMBO && hold_cnt == `UD_HOLD_TICKS);
    assign ud_busy = (state == ST_RUN) && (out_freq_o != target);
    assign ud_sum  = {1'b0, ud_ref} + {1'b0, step_freq};

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ud_ref   <= 16'h0000;
            hold_cnt <= 5'h00;
            up_prev  <= 1'b0;
            dn_prev  <= 1'b0;
        end else begin
            up_prev <= up_lvl;
            dn_prev <= dn_lvl;
            if ((up_lvl ^ dn_lvl) && tenth_tick && hold_cnt != `UD_HOLD_TICKS) begin
                hold_cnt <= hold_cnt + 5'h01;
            end else if (!(up_lvl ^ dn_lvl)) begin
                hold_cnt <= 5'h00;
            end
            if (state == ST_STOP && run_cmd && ctrl[`CTRL_SAVE_EN]) begin
                ud_ref <= saved_freq;
            end else if (ud_on && (up_lvl ^ dn_lvl)) begin
                if (ud_cont && ramp_tick) begin
                    ud_ref <= step_toward(ud_ref, up_lvl ? max_freq : start_freq,
                                          ramp_step);
                end else if (!ud_cont && ctrl[`CTRL_UD_MODE] != `UD_MODE_RAMP && !ud_busy) begin
                    if (up_lvl && !up_prev) begin
                        ud_ref <= (ud_sum > {1'b0, max_freq}) ? max_freq : ud_sum[15:0];
                    end else if (dn_lvl && !dn_prev) begin
                        ud_ref <= (ud_ref > step_freq) ? ud_ref - step_freq : 16'h0000;
                    end
                end
            end
        end
    end

    // Configuration registers; hardware save wins over a same-cycle write
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl           <= `RST_CTRL;
            brk_start_freq <= `RST_BRK_START_FREQ;
            brk_wait       <= `RST_BRK_WAIT;
            stop_level     <= `RST_STOP_LEVEL;
            stop_time      <= `RST_STOP_TIME;
            start_level    <= `RST_START_LEVEL;
            start_time     <= `RST_START_TIME;
            jog_freq       <= `RST_JOG_FREQ;
            max_freq       <= `RST_MAX_FREQ;
            start_freq     <= `RST_START_FREQ;
            step_freq      <= `RST_STEP_FREQ;
            rated_current  <= `RST_RATED_CURRENT;
            ramp_step      <= `RST_RAMP_STEP;
            ref_freq       <= `RST_REF_FREQ;
            for (int i = 0; i < 8; i++) begin
                fsel[i] <= `RST_FSEL;
            end
        end else if (wr_i) begin
            unique case (addr_i)
                `REG_CTRL:           ctrl           <= wr_data_i;
                `REG_BRK_START_FREQ: brk_start_freq <= wr_data_i;
                `REG_BRK_WAIT:       brk_wait       <= wr_data_i[9:0];
                `REG_STOP_LEVEL:     stop_level     <= wr_data_i[7:0];
                `REG_STOP_TIME:      stop_time      <= wr_data_i[9:0];
                `REG_START_LEVEL:    start_level    <= wr_data_i[7:0];
                `REG_START_TIME:     start_time     <= wr_data_i[9:0];
                `REG_JOG_FREQ:       jog_freq       <= wr_data_i;
                `REG_MAX_FREQ:       max_freq       <= wr_data_i;
                `REG_START_FREQ:     start_freq     <= wr_data_i;
                `REG_STEP_FREQ:      step_freq      <= wr_data_i;
                `REG_RATED_CURRENT:  rated_current  <= wr_data_i[10:0];
                `REG_RAMP_STEP:      ramp_step      <= wr_data_i;
                `REG_REF_FREQ:       ref_freq       <= wr_data_i;
                default: begin
                    if (addr_i[5:3] == `REG_FSEL_BASE) begin
                        fsel[addr_i[2:0]] <= wr_data_i[4:0];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            saved_freq <= `RST_SAVED_FREQ;
        end else if (ud_on && ctrl[`CTRL_SAVE_EN] && ctrl[`CTRL_UD_MODE] != `UD_MODE_RAMP
                     && ((up_prev && !up_lvl) || (dn_prev && !dn_lvl))) begin
            saved_freq <= ud_ref;
        end else if (ud_on && ctrl[`CTRL_SAVE_EN] && stop_evt
                     && ctrl[`CTRL_UD_MODE] == `UD_MODE_RAMP) begin
            saved_freq <= ud_ref;
        end else if (ud_on && (|is_clr) && !up_lvl && !dn_lvl) begin
            saved_freq <= 16'h0000;
        end else if (wr_i && addr_i == `REG_SAVED_FREQ) begin
            saved_freq <= wr_data_i;
        end
    end

    // Read port, data valid the cycle after the strobe
    always_comb begin
        unique case (addr_i)
            `REG_CTRL:           next_rd_data = ctrl;
            `REG_BRK_START_FREQ: next_rd_data = brk_start_freq;
            `REG_BRK_WAIT:       next_rd_data = {6'h00, brk_wait};
            `REG_STOP_LEVEL:     next_rd_data = {8'h00, stop_level};
            `REG_STOP_TIME:      next_rd_data = {6'h00, stop_time};
            `REG_START_LEVEL:    next_rd_data = {8'h00, start_level};
            `REG_START_TIME:     next_rd_data = {6'h00, start_time};
            `REG_JOG_FREQ:       next_rd_data = jog_freq;
            `REG_MAX_FREQ:       next_rd_data = max_freq;
            `REG_START_FREQ:     next_rd_data = start_freq;
            `REG_STEP_FREQ:      next_rd_data = step_freq;
            `REG_SAVED_FREQ:     next_rd_data = saved_freq;
            `REG_RATED_CURRENT:  next_rd_data = {5'h00, rated_current};
            `REG_RAMP_STEP:      next_rd_data = ramp_step;
            `REG_REF_FREQ:       next_rd_data = ref_freq;
            `REG_STATUS:         next_rd_data = {8'h00, up_lvl, dn_lvl, jog_on, run_cmd,
                                                 1'b0, 3'(state)};
            `REG_OUT_FREQ:       next_rd_data = out_freq_o;
            `REG_UD_REF:         next_rd_data = ud_ref;
            default: begin
                next_rd_data = (addr_i[5:3] == `REG_FSEL_BASE) ?
                               {11'h000, fsel[addr_i[2:0]]} : 16'h0000;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rd_data_o <= 16'h0000;
        end else if (rd_i) begin
            rd_data_o <= next_rd_data;
        end else begin
            rd_data_o <= 16'h0000;
        end
    end
endmodule : drive_sequencer

/* test/drive_seq_asserts.sv */
// Port assertions for the drive sequencer
`timescale 1ns/1ps
module drive_seq_asserts (
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic [15:0] out_freq_o,
    input wire logic [7:0]  dc_level_o,
    input wire logic [11:0] dc_current_o,
    input wire logic        reverse_o,
    input wire logic        brake_active_o,
    input wire logic        running_o);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    rst_clr_a: assert property (disable iff (1'b0) rst_i |=> !dc_level_o) else $error("rst");
    dc_freq_a: assert property (dc_level_o |-> !out_freq_o) else $error("dc freq");
    brk_flag_a: assert property (brake_active_o == |$past(dc_level_o)) else $error("flag");
    run_dc_a: assert property (running_o |-> !dc_level_o) else $error("run dc");
    lvl_cap_a: assert property (dc_level_o <= 8'hC8) else $error("level");
    cur_zero_a: assert property (!dc_level_o |=> !dc_current_o) else $error("current");
    freq_cap_a: assert property (out_freq_o <= 16'h9C40) else $error("freq");
    dir_hold_a: assert property ($changed(reverse_o) |-> !running_o) else $error("dir");
    cover property ($rose(brake_active_o));
    cover property ($rose(running_o));
    cover property ($rose(reverse_o));
endmodule : drive_seq_asserts
bind drive_sequencer drive_seq_asserts u_chk (.ref_clk_i, .rst_i, .out_freq_o, .dc_level_o,
    .dc_current_o, .reverse_o, .brake_active_o, .running_o);

/* test/terminal_model.sv */
// Model of the terminal pins that feed the drive
`timescale 1ns/1ps
module terminal_model (
    input  wire logic       ref_clk_i,
    input  wire logic       run_req_i,
    input  wire logic [7:0] mfi_req_i,
    output logic            run_o,
    output logic      [7:0] mfi_o);
    always_ff @(posedge ref_clk_i) {run_o, mfi_o} <= {run_req_i, mfi_req_i};
endmodule : terminal_model

/* test/drive_sequencer_tb_top.sv */
// Bench for the drive sequencer
`timescale 1ns/1ps
module drive_sequencer_tb_top;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, run = 1'b0, run_p, rev, brk, rng;
    logic [5:0]  addr = 6'h00;
    logic [15:0] wd = 16'h0000, rdd, frq;
    logic [7:0]  mfi = 8'h00, mfi_p, lvl;
    logic [11:0] cur;
    int          fails = 0, checks = 0, cyc = 0, k;
    always #20 clk = ~clk;
    terminal_model u_term (.ref_clk_i(clk), .run_req_i(run), .mfi_req_i(mfi),
        .run_o(run_p), .mfi_o(mfi_p));
    drive_sequencer #(.TENTH_CYCLES(20), .RAMP_CYCLES(4)) u_dut (.ref_clk_i(clk),
        .rst_i(rst), .addr_i(addr), .wr_data_i(wd), .wr_i(wr), .rd_i(rd), .rd_data_o(rdd),
        .run_i(run_p), .mfi_i(mfi_p), .out_freq_o(frq), .dc_level_o(lvl), .dc_current_o(cur),
        .reverse_o(rev), .brake_active_o(brk), .running_o(rng));
    task chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) fails++;
        if (g !== e) $display("mismatch %0t %h %h", $time, g, e);
    endtask : chk
    task bus(input logic w, input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        {addr, wd, wr, rd} <= {a, d, w, !w};
        @(posedge clk);
        {wr, rd} <= 2'b00;
        @(negedge clk);
        if (!w) chk(rdd, d);
    endtask : bus
    always @(posedge clk) cyc <= cyc + 1;
    always @(posedge clk) if (cyc == 20000) complete_run(1);
    task complete_run(input int late);
        fails += late;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    task t_brake;
        bus(1'b0, 6'h3F, 16'h0000);
        bus(1'b0, 6'h0C, 16'h0107);
        bus(1'b0, 6'h07, 16'h03E8);
        bus(1'b1, 6'h00, 16'h0001);
        bus(1'b1, 6'h0E, 16'h0258);
        bus(1'b1, 6'h06, 16'h0001);
        @(posedge clk) run <= 1'b1;
        wait (frq === 16'h0258);
        @(posedge clk) run <= 1'b0;
        wait (lvl === 8'h32);
        k = cyc;
        chk(frq, 16'h0000);
        repeat (2) @(negedge clk);
        chk({3'h0, brk, cur}, 16'h1083);
        wait (lvl === 8'h00);
        chk(16'((cyc - k) inside {[178:202]}), 16'h0001);
        $display("brake done");
    endtask : t_brake
    task t_jog;
        bus(1'b1, 6'h03, 16'h0000);
        bus(1'b1, 6'h10, 16'h0004);
        bus(1'b1, 6'h11, 16'h001B);
        @(posedge clk) {run, mfi} <= 9'h101;
        wait (frq === 16'h03E8);
        @(posedge clk) {run, mfi} <= 9'h000;
        wait (!rng);
        repeat (40) @(negedge clk);
        chk({7'h00, brk, lvl}, 16'h0000);
        @(posedge clk) mfi <= 8'h02;
        wait (frq === 16'h03E8);
        chk({15'h0000, rev}, 16'h0001);
        $display("jog done");
    endtask : t_jog
    task pins(input logic [7:0] m);
        @(posedge clk) mfi <= m;
        repeat (6) @(posedge clk);
    endtask : pins
    task t_updown;
        @(posedge clk) mfi <= 8'h00;
        wait (!rng);
        bus(1'b1, 6'h00, 16'h0160);
        bus(1'b1, 6'h0A, 16'h03E8);
        bus(1'b1, 6'h12, 16'h000F);
        bus(1'b1, 6'h13, 16'h0010);
        bus(1'b1, 6'h14, 16'h0019);
        bus(1'b1, 6'h15, 16'h000B);
        pins(8'h04);
        pins(8'h00);
        bus(1'b0, 6'h1A, 16'h03E8);
        bus(1'b0, 6'h0B, 16'h03E8);
        pins(8'h14);
        bus(1'b0, 6'h0B, 16'h03E8);
        pins(8'h00);
        bus(1'b0, 6'h0B, 16'h07D0);
        pins(8'h10);
        bus(1'b0, 6'h0B, 16'h0000);
        pins(8'h08);
        pins(8'h0C);
        pins(8'h00);
        bus(1'b0, 6'h1A, 16'h03E8);
        @(posedge clk) run <= 1'b1;
        wait (frq === 16'h03E8);
        @(posedge clk) run <= 1'b0;
        wait (!rng);
        pins(8'h20);
        chk({8'h00, lvl}, 16'h0032);
        pins(8'h00);
        $display("updown done");
    endtask : t_updown
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_brake;
        t_jog;
        t_updown;
        complete_run(0);
    end
endmodule : drive_sequencer_tb_top
